/* bil_crc.sv */
// Byte-wide reflected CRC-32 accumulator
module bil_crc
   import bil_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Byte stream
   input  wire logic       init_i,
   input  wire logic       en_i,
   input  wire logic [7:0] byte_i,
   // Running residue
   output logic [31:0]     crc_o
);

   typedef struct packed {
      logic [31:0] crc;
   } bil_crc_t;

   bil_crc_t q_r, q_nxt;

   assign crc_o = q_r.crc;

   always_comb begin
      q_nxt = q_r;
      if (!rst_b_i || init_i) begin
         q_nxt.crc = CRC_INIT;
      end else if (en_i) begin
         q_nxt.crc = bil_crc_byte(q_r.crc, byte_i);
      end
   end

   always_ff @(posedge clk_i) begin
      q_r <= q_nxt;
   end

endmodule // bil_crc

/* bil_fifo.sv */
// Single-clock byte FIFO between the link crossing and the loader
module bil_fifo
   import bil_pkg::*;
#(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // Fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);

   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } bil_fifo_t;

   bil_fifo_t q_r, q_nxt;
   logic      push, pop;

   assign in_ready_o  = (q_r.cnt != (AW + 1)'(D));
   assign out_valid_o = (q_r.cnt != '0);
   assign out_data_o  = q_r.mem[q_r.rp];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      q_nxt = q_r;
      if (push) begin
         q_nxt.mem[q_r.wp] = in_data_i;
         q_nxt.wp          = q_r.wp + 1'b1;
      end
      if (pop) begin
         q_nxt.rp = q_r.rp + 1'b1;
      end
      q_nxt.cnt = q_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      if (!rst_b_i) begin
         q_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      q_r <= q_nxt;
   end

endmodule // bil_fifo

/* bil_flash_model.sv */
// Serial boot flash model answering single-line reads
module bil_flash_model (
   // Serial link
   input  wire logic   cs_b_i,
   input  wire logic   sck_i,
   input  wire logic   mosi_i,
   output logic        miso_o,
   // Bench control
   input  wire logic   slow_i,
   output logic [31:0] hdr_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0]  mem [0:127];
   int unsigned cnt;
   int unsigned idx;

   initial begin
      cnt    = 0;
      hdr_o  = 32'h00000000;
      miso_o = 1'b0;
   end

   // Header shifts in on rising sck; deselect restarts the frame
   always @(posedge sck_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         cnt    <= 0;
         miso_o <= ~miso_o;   // Released line must not keep its last bit
      end else begin
         if (cnt < 32) begin
            hdr_o <= {hdr_o[30:0], mosi_i};
         end
         cnt <= cnt + 1;
      end
   end

   // Data leaves after each falling sck, top bit of each byte first
   always @(negedge sck_i) begin
      if (!cs_b_i && cnt >= 32) begin
         idx = cnt - 32;
         if (slow_i) begin
            #30;   // Late answer, still inside the low half of sck
         end
         miso_o = mem[(idx / 8) % 128][7 - (idx % 8)];
      end
   end
endmodule // bil_flash_model

/* bil_loader.sv */
// Reset release, boot source choice and flash image loader
module bil_loader
   import bil_pkg::*;
(
   // Core clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   // Flash link
   input  wire logic              lnk_clk_i,
   output logic                   fl_cs_b_o,
   output logic                   fl_sck_o,
   output logic                   fl_mosi_o,
   input  wire logic              fl_miso_i,
   // OTP read port
   output logic                   otp_rd_o,
   output logic [OTP_AW-1:0]      otp_addr_o,
   input  wire logic [31:0]       otp_data_i,
   // RAM write port
   output logic                   ram_we_o,
   output logic [RAM_AW-1:0]      ram_addr_o,
   output logic [31:0]            ram_wdata_o,
   // Boot status
   output logic                   gpio_pd_o,
   output logic                   core_rst_b_o,
   output logic                   boot_otp_o,
   output logic                   boot_err_o,
   output logic [31:0]            sec_reg_o,
   output logic [31:0]            exec_addr_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      bil_state_t        st;
      logic [7:0]        dly;
      logic [31:0]       sec;
      logic [31:0]       word;
      logic [1:0]        bcnt;
      logic [15:0]       left;
      logic [RAM_AW-1:0] addr;
      logic [RAM_AW-1:0] waddr;
      logic              we;
      logic [31:0]       wdata;
      logic              run;
      logic              err;
      logic              pd;
      logic              core_rst_b;
      logic              otp_boot;
      logic              rq1;
      logic              rq2;
      logic              rq3;
      logic              ack;
      logic              pend;
      logic [7:0]        byte_v;
   } bil_main_t;

   typedef struct packed {
      logic       rs1;
      logic       rs2;
      logic       run1;
      logic       run2;
      logic       ak1;
      logic       ak2;
      logic       mi1;
      logic       mi2;
      bil_link_t  ph;
      logic [2:0] cnt;
      logic [5:0] bits;
      logic [31:0] sh;
      logic       req;
      logic [7:0] byte_v;
      logic [7:0] rx;
   } bil_lnk_t;

   bil_main_t m_r, m_nxt;
   bil_lnk_t  l_r, l_nxt;

   logic        f_ir, f_ov, f_or, take, last_b, crc_init, crc_en;
   logic [7:0]  f_od;
   logic [31:0] crc_val, wd;

   // ---------------------------------------------------------------
   // Byte FIFO and checksum
   // ---------------------------------------------------------------
   bil_fifo #(
      .W (BYTE_W),
      .D (FIFO_DEPTH)
   ) u_bil_fifo (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (m_r.pend),
      .in_ready_o  (f_ir),
      .in_data_i   (m_r.byte_v),
      .out_valid_o (f_ov),
      .out_ready_i (f_or),
      .out_data_o  (f_od)
   );

   bil_crc u_bil_crc (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .init_i  (crc_init),
      .en_i    (crc_en),
      .byte_i  (f_od),
      .crc_o   (crc_val)
   );

   assign f_or     = (m_r.st == ST_SIZE) || (m_r.st == ST_BODY) || (m_r.st == ST_CHECK);
   assign take     = f_ov && f_or;
   assign last_b   = take && (m_r.bcnt == 2'h3);
   assign wd       = {f_od, m_r.word[31:8]};
   assign crc_init = (m_r.st == ST_SEC_WT);
   assign crc_en   = take && (m_r.st != ST_CHECK);

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign otp_rd_o     = (m_r.st == ST_SEC_RD);
   assign otp_addr_o   = SEC_ROW;
   assign ram_we_o     = m_r.we;
   assign ram_addr_o   = m_r.waddr;
   assign ram_wdata_o  = m_r.wdata;
   assign gpio_pd_o    = m_r.pd;
   assign core_rst_b_o = m_r.core_rst_b;
   assign boot_otp_o   = m_r.otp_boot;
   assign boot_err_o   = m_r.err;
   assign sec_reg_o    = m_r.sec;
   assign exec_addr_o  = EXEC_ADDR;
   assign fl_cs_b_o    = (l_r.ph == LK_IDLE);
   assign fl_sck_o     = l_r.cnt[2];
   assign fl_mosi_o    = l_r.sh[31];

   // ---------------------------------------------------------------
   // Core domain: crossing, delay, source choice, loader
   // ---------------------------------------------------------------
   always_comb begin
      m_nxt     = m_r;
      m_nxt.we  = 1'b0;
      m_nxt.pd  = 1'b0;
      m_nxt.rq1 = l_r.req;
      m_nxt.rq2 = m_r.rq1;
      m_nxt.rq3 = m_r.rq2;
      // Ack only once the FIFO takes the byte, so a full FIFO stalls the link
      if (m_r.pend && f_ir) begin
         m_nxt.pend = 1'b0;
         m_nxt.ack  = ~m_r.ack;
      end
      if (m_r.rq2 != m_r.rq3) begin
         m_nxt.pend   = 1'b1;
         m_nxt.byte_v = l_r.byte_v;
      end
      if (take) begin
         m_nxt.word = wd;
         m_nxt.bcnt = m_r.bcnt + 2'h1;
      end
      case (m_r.st)
         ST_DELAY: begin
            m_nxt.dly = m_r.dly + 8'h01;
            if (m_r.dly == RST_DLY_LAST) begin
               m_nxt.st = ST_SEC_RD;
            end
         end
         ST_SEC_RD: begin
            m_nxt.st = ST_SEC_WT;
         end
         ST_SEC_WT: begin
            m_nxt.sec = otp_data_i;
            if (otp_data_i[SEC_BOOT_BIT]) begin
               m_nxt.otp_boot = 1'b1;
               m_nxt.st       = ST_RUN;
            end else begin
               m_nxt.run = 1'b1;
               m_nxt.st  = ST_SIZE;
            end
         end
         ST_SIZE: begin
            if (last_b) begin
               m_nxt.left = wd[15:0];
               // An image larger than RAM can never be placed
               if (wd > RAM_WORDS) begin
                  m_nxt.st = ST_ERR;
               end else if (wd == '0) begin
                  m_nxt.st = ST_CHECK;
               end else begin
                  m_nxt.st = ST_BODY;
               end
            end
         end
         ST_BODY: begin
            if (last_b) begin
               m_nxt.we    = 1'b1;
               m_nxt.wdata = wd;
               m_nxt.waddr = m_r.addr;
               m_nxt.addr  = m_r.addr + 1'b1;
               m_nxt.left  = m_r.left - 16'h0001;
               if (m_r.left == 16'h0001) begin
                  m_nxt.st = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            if (last_b) begin
               if ((wd == CRC_BYPASS) || (wd == ~crc_val)) begin
                  m_nxt.st = ST_RUN;
               end else begin
                  m_nxt.st = ST_ERR;
               end
            end
         end
         ST_RUN: begin
         end
         ST_ERR: begin
         end
         default: begin
            m_nxt.st = ST_ERR;
         end
      endcase
      m_nxt.run        = m_nxt.run && (m_nxt.st != ST_RUN) && (m_nxt.st != ST_ERR);
      m_nxt.core_rst_b = (m_nxt.st == ST_RUN);
      m_nxt.err        = (m_nxt.st == ST_ERR);
      if (!rst_b_i) begin
         m_nxt    = '0;
         m_nxt.pd = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      m_r <= m_nxt;
   end

   // ---------------------------------------------------------------
   // Link domain: serial read, one byte per handshake
   // ---------------------------------------------------------------
   always_comb begin
      l_nxt      = l_r;
      l_nxt.rs1  = rst_b_i;
      l_nxt.rs2  = l_r.rs1;
      l_nxt.run1 = m_r.run;
      l_nxt.run2 = l_r.run1;
      l_nxt.ak1  = m_r.ack;
      l_nxt.ak2  = l_r.ak1;
      l_nxt.mi1  = fl_miso_i;
      l_nxt.mi2  = l_r.mi1;
      case (l_r.ph)
         LK_IDLE: begin
            if (l_r.run2) begin
               l_nxt.ph   = LK_HDR;
               l_nxt.sh   = {FL_RD_CMD, FL_BASE};
               l_nxt.cnt  = '0;
               l_nxt.bits = '0;
            end
         end
         LK_HDR: begin
            l_nxt.cnt = l_r.cnt + 3'h1;
            if (l_r.cnt == SCK_LAST) begin
               l_nxt.sh   = {l_r.sh[30:0], 1'b0};
               l_nxt.bits = l_r.bits + 6'h01;
               if (l_r.bits == FL_HDR_LAST) begin
                  l_nxt.ph   = LK_DATA;
                  l_nxt.bits = '0;
               end
            end
         end
         LK_DATA: begin
            // Stall with the clock low until the previous byte is acked
            if (!((l_r.cnt == '0) && (l_r.bits == '0) && (l_r.req != l_r.ak2))) begin
               l_nxt.cnt = l_r.cnt + 3'h1;
               if (l_r.cnt == SCK_LAST) begin
                  l_nxt.rx   = {l_r.rx[6:0], l_r.mi2};
                  l_nxt.bits = l_r.bits + 6'h01;
                  if (l_r.bits == BYTE_LAST) begin
                     l_nxt.byte_v = {l_r.rx[6:0], l_r.mi2};
                     l_nxt.req    = ~l_r.req;
                     l_nxt.bits   = '0;
                  end
               end
            end
         end
         default: begin
            l_nxt.ph = LK_IDLE;
         end
      endcase
      if (!l_r.run2) begin
         l_nxt.ph  = LK_IDLE;
         l_nxt.cnt = '0;
         l_nxt.sh  = '0;
      end
      if (!l_r.rs2) begin
         l_nxt.ph     = LK_IDLE;
         l_nxt.cnt    = '0;
         l_nxt.bits   = '0;
         l_nxt.sh     = '0;
         l_nxt.req    = 1'b0;
         l_nxt.byte_v = '0;
         l_nxt.rx     = '0;
      end
   end

   always_ff @(posedge lnk_clk_i) begin
      l_r <= l_nxt;
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Named copy of the link run request, read by the reset check
   logic fl_run_w;
   assign fl_run_w = m_r.run;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_core_held_rst: assert property (disable iff (1'b0) !rst_b_i |=> !core_rst_b_o)
      else $error("core released during reset");
   a_pull_down_rst: assert property (disable iff (1'b0) !rst_b_i |=> gpio_pd_o && !fl_run_w)
      else $error("pull-down missing in reset");
   a_boot_delay: assert property ($rose(otp_rd_o) |-> $past(m_r.dly) == RST_DLY_LAST)
      else $error("boot started at wrong delay");
   a_secure_src: assert property (m_r.st == ST_SEC_WT && otp_data_i[SEC_BOOT_BIT]
      |=> boot_otp_o && core_rst_b_o && !m_r.run)
      else $error("secure boot not taken");
   a_flash_src: assert property (m_r.st == ST_SEC_WT && !otp_data_i[SEC_BOOT_BIT]
      |=> m_r.run && !boot_otp_o ##1 !core_rst_b_o)
      else $error("flash boot not started");
   a_first_addr: assert property ($rose(m_r.st == ST_BODY) |-> m_r.addr == '0)
      else $error("first word not at RAM bottom");
   a_size_order: assert property (m_r.st == ST_SIZE && take && m_r.bcnt == 2'h0
      |=> m_r.word[31:24] == $past(f_od))
      else $error("size byte order wrong");
   a_bypass_run: assert property (m_r.st == ST_CHECK && last_b && wd == CRC_BYPASS
      |=> core_rst_b_o && !boot_err_o)
      else $error("bypass word did not start");
   a_crc_fail: assert property (m_r.st == ST_CHECK && last_b && wd != CRC_BYPASS
      && wd != ~crc_val |=> (boot_err_o && !core_rst_b_o) [*3])
      else $error("bad image started");
   a_crc_preset: assert property (crc_init |=> crc_val == CRC_INIT)
      else $error("checksum not preset");

   c_secure_boot: cover property (m_r.st == ST_SEC_WT && otp_data_i[SEC_BOOT_BIT]);
   c_crc_pass: cover property (m_r.st == ST_CHECK && last_b && wd == ~crc_val);
   c_bypass: cover property (m_r.st == ST_CHECK && last_b && wd == CRC_BYPASS);
   c_fifo_full: cover property (m_r.pend && !f_ir);

endmodule // bil_loader

/* bil_pkg.sv */
// Shared constants, types and the CRC step function for the boot image loader
package bil_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS      = 100;
   localparam int RST_DLY_NS  = 15000;
   localparam int RST_DLY_CYC = (RST_DLY_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] RST_DLY_LAST = 8'(RST_DLY_CYC - 1);

   // ---------------------------------------------------------------
   // Image format and checksum
   // ---------------------------------------------------------------
   localparam logic [31:0] CRC_POLY   = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_BYPASS = 32'h0D15AB1E;
   localparam logic [31:0] EXEC_ADDR  = 32'h00000000;
   localparam int          RAM_AW     = 15;
   localparam logic [31:0] RAM_WORDS  = 32'h00008000;

   // ---------------------------------------------------------------
   // Security word and flash access
   // ---------------------------------------------------------------
   localparam int          SEC_BOOT_BIT = 5;
   localparam int          OTP_AW       = 11;
   localparam logic [10:0] SEC_ROW      = 11'h7FF;
   localparam logic [7:0]  FL_RD_CMD    = 8'h03;
   localparam logic [23:0] FL_BASE      = 24'h000000;
   localparam logic [5:0]  FL_HDR_LAST  = 6'h1F;
   localparam logic [2:0]  SCK_LAST     = 3'h7;
   localparam logic [5:0]  BYTE_LAST    = 6'h07;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          BYTE_W       = 8;

   typedef enum logic [3:0] {
      ST_DELAY, ST_SEC_RD, ST_SEC_WT, ST_SIZE, ST_BODY, ST_CHECK, ST_RUN, ST_ERR
   } bil_state_t;

   typedef enum logic [1:0] {LK_IDLE, LK_HDR, LK_DATA} bil_link_t;

   // One byte through the reflected CRC, low bit first
   function automatic logic [31:0] bil_crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

endpackage

/* tb_top.sv */
// Self-checking bench for the boot image loader
module tb_top
   import bil_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic              clk_i = 1'b0;
   logic              lnk_clk_i = 1'b0;
   logic              rst_b_i = 1'b0;
   logic [31:0]       otp_data_i = 32'h00000000;
   logic              fl_cs_b_o, fl_sck_o, fl_mosi_o, fl_miso_i;
   logic              otp_rd_o, ram_we_o, gpio_pd_o, core_rst_b_o, boot_otp_o, boot_err_o;
   logic [OTP_AW-1:0] otp_addr_o;
   logic [RAM_AW-1:0] ram_addr_o;
   logic [31:0]       ram_wdata_o, sec_reg_o, exec_addr_o, hdr, sec_word;
   logic              slow;
   logic [31:0]       exp_w [$];
   logic [31:0]       ram_q [$];
   logic [31:0]       addr_q [$];
   int                err_total = 0;
   int                samples_checked = 0;
   int                cs_falls = 0;
   int                otp_hold = 0;

   always #50 clk_i = ~clk_i;
   initial begin
      #3;
      forever #6 lnk_clk_i = ~lnk_clk_i;
   end

   bil_loader u_bil_loader (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .lnk_clk_i(lnk_clk_i),
      .fl_cs_b_o(fl_cs_b_o), .fl_sck_o(fl_sck_o), .fl_mosi_o(fl_mosi_o), .fl_miso_i(fl_miso_i),
      .otp_rd_o(otp_rd_o), .otp_addr_o(otp_addr_o), .otp_data_i(otp_data_i),
      .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o),
      .gpio_pd_o(gpio_pd_o), .core_rst_b_o(core_rst_b_o), .boot_otp_o(boot_otp_o),
      .boot_err_o(boot_err_o), .sec_reg_o(sec_reg_o), .exec_addr_o(exec_addr_o)
   );

   bil_flash_model u_bil_flash_model (
      .cs_b_i(fl_cs_b_o), .sck_i(fl_sck_o), .mosi_i(fl_mosi_o), .miso_o(fl_miso_i),
      .slow_i(slow), .hdr_o(hdr)
   );

   // ---------------------------------------------------------------
   // Far-side models and monitors
   // ---------------------------------------------------------------
   always @(negedge clk_i) begin
      if (otp_rd_o === 1'b1) begin
         otp_data_i <= sec_word;
         otp_hold   <= 2;
      end else if (otp_hold != 0) begin
         otp_hold <= otp_hold - 1;
      end else begin
         otp_data_i <= ~sec_word;   // Stale data would hide a late sample
      end
   end

   // Sampled mid-cycle, where the registered write pulse has settled
   always @(negedge clk_i) begin
      if (ram_we_o === 1'b1) begin
         ram_q.push_back(ram_wdata_o);
         addr_q.push_back(32'(ram_addr_o));
      end
   end

   always @(negedge fl_cs_b_o) cs_falls++;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Supply taken as settled; a full millisecond would only slow the run
   task automatic apply_reset();
      rst_b_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk(gpio_pd_o, 32'h1, "pull-downs");
      chk(core_rst_b_o, 32'h0, "core held");
      chk(boot_err_o, 32'h0, "error cleared");
      chk(fl_cs_b_o, 32'h1, "flash idle");
      rst_b_i = 1'b1;
   endtask

   task automatic load_image(input logic [31:0] size, input int mode);
      logic [7:0]  img [$];
      logic [31:0] c;
      logic [31:0] w;
      img = {};
      exp_w = {};
      for (int i = 0; i < 4; i++) img.push_back(size[8*i +: 8]);
      for (int k = 0; k < size; k++) begin
         w = 32'hA1B2C3D4 + 32'h01030507 * k;
         exp_w.push_back(w);
         for (int i = 0; i < 4; i++) img.push_back(w[8*i +: 8]);
      end
      c = 32'hFFFFFFFF;
      foreach (img[j]) begin
         for (int b = 0; b < 8; b++) begin
            c = (c[0] ^ img[j][b]) ? ({1'b0, c[31:1]} ^ 32'hEDB88320) : {1'b0, c[31:1]};
         end
      end
      c = ~c;
      if (mode == 1) c = 32'h0D15AB1E;
      if (mode == 2) c = c ^ 32'h00000100;
      for (int i = 0; i < 4; i++) img.push_back(c[8*i +: 8]);
      for (int j = 0; j < 128; j++) begin
         u_bil_flash_model.mem[j] = (j < img.size()) ? img[j] : 8'hA5;
      end
   endtask

   task automatic do_boot(input logic [31:0] sec, input logic [31:0] size, input int mode);
      int n;
      sec_word = sec;
      load_image(size, mode);
      cs_falls = 0;
      apply_reset();
      // Cleared only now, so a write cut short by this reset is not counted
      ram_q = {};
      addr_q = {};
      n = 0;
      while (otp_rd_o !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      chk(32'(n >= 150 && n <= 153), 32'h1, "boot delay");
      chk(otp_addr_o, SEC_ROW, "security row");
      chk(core_rst_b_o, 32'h0, "no start before choice");
      chk(gpio_pd_o, 32'h0, "pull-downs off");
      n = 0;
      while (core_rst_b_o !== 1'b1 && boot_err_o !== 1'b1 && n < 3000) begin
         @(negedge clk_i);
         n++;
      end
      chk(32'(n < 3000), 32'h1, "boot finished");
      repeat (5) @(negedge clk_i);
      chk(sec_reg_o, sec, "security word");
      chk(exec_addr_o, 32'h0, "start address");
   endtask

   task automatic chk_flash(input logic ok);
      chk(hdr, 32'h03000000, "read header");
      chk(boot_otp_o, 32'h0, "source flash");
      chk(cs_falls, 32'h1, "one burst");
      chk(fl_cs_b_o, 32'h1, "deselect");
      chk(core_rst_b_o, ok, "start");
      chk(boot_err_o, !ok, "error flag");
   endtask

   task automatic chk_ram();
      chk(ram_q.size(), exp_w.size(), "word count");
      foreach (exp_w[i]) begin
         if (i < ram_q.size()) begin
            chk(addr_q[i], i, "word address");
            chk(ram_q[i], exp_w[i], "word data");
         end
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_secure();
      do_boot(32'h00000020, 3, 0);
      chk(boot_otp_o, 32'h1, "source otp");
      chk(core_rst_b_o, 32'h1, "start from otp");
      chk(cs_falls, 32'h0, "flash untouched");
      chk(ram_q.size(), 32'h0, "no copy");
   endtask

   // All other security bits set, slow flash answers
   task automatic t_good();
      slow = 1'b1;
      do_boot(32'hFFFFFFDF, 5, 0);
      chk_flash(1'b1);
      chk_ram();
      slow = 1'b0;
   endtask

   task automatic t_bypass();
      do_boot(32'h00000000, 2, 1);
      chk_flash(1'b1);
      chk_ram();
   endtask

   task automatic t_bad();
      do_boot(32'h00000000, 2, 2);
      chk_flash(1'b0);
   endtask

   task automatic t_empty();
      do_boot(32'h00000000, 0, 0);
      chk_flash(1'b1);
      chk_ram();
   endtask

   task automatic t_abort();
      sec_word = 32'h00000000;
      load_image(4, 0);
      apply_reset();
      repeat (250) @(negedge clk_i);
      chk(fl_cs_b_o, 32'h0, "loading");
      chk(core_rst_b_o, 32'h0, "held while loading");
      // Reset lands in mid-burst; the block must boot cleanly again
      do_boot(32'h00000000, 4, 0);
      chk_flash(1'b1);
      chk_ram();
   endtask

   initial begin
      slow = 1'b0;
      sec_word = 32'h00000000;
      @(negedge clk_i);
      t_secure();
      t_good();
      t_bypass();
      t_bad();
      t_empty();
      t_abort();
      final_report();
   end

   // Seven boots need well under half a millisecond
   initial begin
      #1000000;
      err_total++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report();
   end
endmodule // tb_top
